// ---- undervolt_pkg.sv ----
// Package for the supply undervoltage monitor: register map, fields, reset values.
// Assumes an 8-bit register port addressed by the printed offsets.
package undervolt_pkg;
	localparam int          ADDR_W            = 12;
	localparam logic [11:0] FLAGS_THR_ADDR    = 12'hFC6;
	localparam logic [11:0] MODE_EN_ADDR      = 12'hFC7;
	localparam logic [7:0]  FLAGS_THR_RESET   = 8'h20;
	localparam logic [7:0]  MODE_EN_RESET     = 8'h00;
	localparam int          BIT_STICKY        = 3;
	localparam int          BIT_LIVE          = 2;
	localparam int          BIT_ACTION        = 1;
	localparam int          BIT_ENABLE        = 0;
	localparam int          SYNC_STAGES       = 2;
	localparam logic [1:0]  THRESHOLD_4V50    = 2'h0;
	localparam logic [7:0]  UNMAPPED_READ     = 8'h00;
	typedef enum logic [2:0]
	{
		ST_IDLE   = 3'b001,
		ST_IRQ    = 3'b010,
		ST_RESET  = 3'b100
	} action_state_t;
endpackage

// ---- reset_sync.sv ----
// Reset release synchroniser.
// Assumes rst_n may deassert at any time relative to sys_clk.
`timescale 1ns/1ns
module reset_sync
(
	input  wire logic sys_clk,
	input  wire logic rst_n,
	output logic      rst_sync_n
);
	logic [1:0] stage_r;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			stage_r <= 2'h0;
		else
			stage_r <= {stage_r[0], 1'b1};
	end

	assign rst_sync_n = stage_r[1];
endmodule

// ---- level_sync.sv ----
// Two-flop synchroniser for one asynchronous level.
// Assumes the first stage is read only by the second.
`timescale 1ns/1ns
module level_sync
(
	input  wire logic sys_clk,
	input  wire logic rst_sync_n,
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_r;
	logic hold_r;

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			meta_r <= 1'b0;
			hold_r <= 1'b0;
		end
		else
		begin
			meta_r <= async_in;
			hold_r <= meta_r;
		end
	end

	assign sync_out = hold_r;
endmodule

// ---- supply_undervolt_monitor.sv ----
// Control logic of the supply undervoltage detector: two 8-bit registers,
// sticky and live flags, interrupt or reset request.
// Assumes rst_n is only power-on or external pin reset; the comparator is async.
`timescale 1ns/1ns
//
// Contract
// - action_select chooses interrupt or reset request
// - detect_enable low blocks every request
// - Reset mode requests reset while below
// - Interrupt mode pulses irq on crossing
// - Irq may fire on either crossing direction
// - Sticky flag captures below, holds after recovery
// - Writing 0 clears sticky, 1 ignored
// - Detection wins over same-cycle clear
// - Live flag shows current comparison
// - First register reset only by rst_n
// - Second register survives own reset request
// - Bit 6 of first register undefined
// - Second register bits 7:6 read zero
// - Reset request continuous while below
// - Sticky stays set after enable cleared
// - Live and sticky set on the same clock
module supply_undervolt_monitor
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        cmp_below,
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             undervolt_irq,
	output logic             vdet_reset_req
);
	logic                        rst_sync_n;
	logic                        below_sync;
	logic                        below_prev_r;
	logic                        sticky_r;
	logic                        sticky_nxt;
	logic                        live_r;
	logic [1:0]                  threshold_r;
	logic [2:0]                  flags_spare_r;
	logic                        action_r;
	logic                        enable_r;
	logic [3:0]                  mode_spare_r;
	logic [7:0]                  rdata_r;
	logic [7:0]                  rdata_nxt;
	logic                        irq_r;
	logic                        reset_req_r;
	logic                        wr_flags;
	logic                        wr_mode;
	logic                        crossing;
	logic                        rd_flags;
	logic                        rd_mode;
	logic                        set_sticky;
	logic                        clear_sticky;
	logic                        irq_mode_now;
	logic                        irq_mode_next;
	logic                        irq_event;
	logic                        irq_enter;
	logic                        reset_cond;
	logic [7:0]                  flags_image;
	logic [7:0]                  mode_image;
	genvar                       spare_bit;
	genvar                       rd_bit;
	undervolt_pkg::action_state_t state_r;
	undervolt_pkg::action_state_t state_nxt;

	reset_sync u_reset_sync
	(
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.rst_sync_n (rst_sync_n)
	);

	// Comparator into the clock domain
	level_sync u_cmp_sync
	(
		.sys_clk    (sys_clk),
		.rst_sync_n (rst_sync_n),
		.async_in   (cmp_below),
		.sync_out   (below_sync)
	);

	assign wr_flags = reg_wr && (reg_addr == undervolt_pkg::FLAGS_THR_ADDR);
	assign wr_mode  = reg_wr && (reg_addr == undervolt_pkg::MODE_EN_ADDR);
	assign rd_flags = reg_rd && (reg_addr == undervolt_pkg::FLAGS_THR_ADDR);
	assign rd_mode  = reg_rd && (reg_addr == undervolt_pkg::MODE_EN_ADDR);

	// Either edge of the sampled comparator counts as a crossing
	assign crossing = below_sync ^ below_prev_r;

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			below_prev_r <= 1'b0;
		else
			below_prev_r <= below_sync;
	end

	// Mode register; vdet_reset_req does not reach rst_n
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			action_r <= undervolt_pkg::MODE_EN_RESET[undervolt_pkg::BIT_ACTION];
		else if (wr_mode)
			action_r <= reg_wdata[undervolt_pkg::BIT_ACTION];
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			enable_r <= undervolt_pkg::MODE_EN_RESET[undervolt_pkg::BIT_ENABLE];
		else if (wr_mode)
			enable_r <= reg_wdata[undervolt_pkg::BIT_ENABLE];
	end

	// Bits 5:2 of the second register, plain storage per bit
	generate
		for (spare_bit = 0; spare_bit < 4; spare_bit = spare_bit + 1)
		begin : g_mode_spare
			always_ff @(posedge sys_clk or negedge rst_sync_n)
			begin
				if (!rst_sync_n)
					mode_spare_r[spare_bit] <= undervolt_pkg::MODE_EN_RESET[spare_bit + 2];
				else if (wr_mode)
					mode_spare_r[spare_bit] <= reg_wdata[spare_bit + 2];
			end
		end
	endgenerate

	// Threshold field of the first register
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			threshold_r <= undervolt_pkg::FLAGS_THR_RESET[1:0];
		else if (wr_flags)
			threshold_r <= reg_wdata[1:0];
	end

	// Fixed bits 7, 5 and 4 of the first register as plain storage
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			flags_spare_r <= {undervolt_pkg::FLAGS_THR_RESET[7],
				undervolt_pkg::FLAGS_THR_RESET[5:4]};
		else if (wr_flags)
			flags_spare_r <= {reg_wdata[7], reg_wdata[5:4]};
	end

	// Software clear and hardware set of the sticky flag
	assign clear_sticky = wr_flags && !reg_wdata[undervolt_pkg::BIT_STICKY];
	assign set_sticky   = enable_r && below_sync;

	// Sticky flag: set wins, write 0 clears, write 1 ignored
	always_comb
	begin
		sticky_nxt = sticky_r;
		if (clear_sticky)
			sticky_nxt = 1'b0;
		if (set_sticky)
			sticky_nxt = 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			sticky_r <= undervolt_pkg::FLAGS_THR_RESET[undervolt_pkg::BIT_STICKY];
		else
			sticky_r <= sticky_nxt;
	end

	// Live flag follows the comparison while detect_enable is set, with no history
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			live_r <= undervolt_pkg::FLAGS_THR_RESET[undervolt_pkg::BIT_LIVE];
		else
			live_r <= enable_r && below_sync;
	end

	// Response selection from the mode bits
	always_comb
	begin
		state_nxt = undervolt_pkg::ST_IDLE;
		case (state_r)
			undervolt_pkg::ST_IDLE:
			begin
				if (enable_r && action_r)
					state_nxt = undervolt_pkg::ST_RESET;
				else if (enable_r)
					state_nxt = undervolt_pkg::ST_IRQ;
			end
			undervolt_pkg::ST_IRQ:
			begin
				if (!enable_r)
					state_nxt = undervolt_pkg::ST_IDLE;
				else if (action_r)
					state_nxt = undervolt_pkg::ST_RESET;
				else
					state_nxt = undervolt_pkg::ST_IRQ;
			end
			undervolt_pkg::ST_RESET:
			begin
				if (!enable_r)
					state_nxt = undervolt_pkg::ST_IDLE;
				else if (!action_r)
					state_nxt = undervolt_pkg::ST_IRQ;
				else
					state_nxt = undervolt_pkg::ST_RESET;
			end
			default:
				state_nxt = undervolt_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			state_r <= undervolt_pkg::ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Interrupt mode now and after this edge
	assign irq_mode_now  = (state_r == undervolt_pkg::ST_IRQ);
	assign irq_mode_next = (state_nxt == undervolt_pkg::ST_IRQ);

	// Crossing while the mode holds; entering irq mode while below also fires
	assign irq_event = irq_mode_now && irq_mode_next && crossing;
	assign irq_enter = !irq_mode_now && irq_mode_next && below_sync;

	// Interrupt pulse; nothing fires in the cycle detection is switched off
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			irq_r <= 1'b0;
		else
			irq_r <= irq_event || irq_enter;
	end

	// Reset request held while below in reset mode
	assign reset_cond = (state_nxt == undervolt_pkg::ST_RESET) && below_sync;

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			reset_req_r <= 1'b0;
		else
			reset_req_r <= reset_cond;
	end

	assign undervolt_irq  = irq_r;
	assign vdet_reset_req = reset_req_r;

	// Image of the first register; bit 6 reads 0 here
	always_comb
	begin
		flags_image                            = 8'h00;
		flags_image[7]                         = flags_spare_r[2];
		flags_image[6]                         = 1'b0;
		flags_image[5:4]                       = flags_spare_r[1:0];
		flags_image[undervolt_pkg::BIT_STICKY] = sticky_r;
		flags_image[undervolt_pkg::BIT_LIVE]   = live_r;
		flags_image[1:0]                       = threshold_r;
	end

	// Image of the second register; top two bits are not stored
	always_comb
	begin
		mode_image                            = 8'h00;
		mode_image[7:6]                       = 2'h0;
		mode_image[5:2]                       = mode_spare_r;
		mode_image[undervolt_pkg::BIT_ACTION] = action_r;
		mode_image[undervolt_pkg::BIT_ENABLE] = enable_r;
	end

	// Read select per bit; unmapped addresses read the fixed pattern
	generate
		for (rd_bit = 0; rd_bit < 8; rd_bit = rd_bit + 1)
		begin : g_rd_bit
			assign rdata_nxt[rd_bit] = rd_flags ? flags_image[rd_bit]
				: rd_mode ? mode_image[rd_bit]
				: undervolt_pkg::UNMAPPED_READ[rd_bit];
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			rdata_r <= 8'h00;
		else
			rdata_r <= rdata_nxt;
	end

	assign reg_rdata = rdata_r;
endmodule

// ---- uv_chk_assertions.sv ----
// Port checker for the undervoltage monitor.
// Assumes it is bound to supply_undervolt_monitor.
`timescale 1ns/1ns
module uv_chk
(
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        cmp_below,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        undervolt_irq,
	input wire logic        vdet_reset_req
);
	logic [1:0] mode_r;
	logic [2:0] age_r;
	logic [3:0] cmp_d;
	wire        ok = age_r == 3'h7;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Mode copy and its age, so checks skip mode changes
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_r <= 2'h0;
			age_r  <= 3'h7;
		end
		else if (reg_wr && reg_addr == undervolt_pkg::MODE_EN_ADDR)
		begin
			mode_r <= reg_wdata[1:0];
			age_r  <= 3'h0;
		end
		else if (!ok)
			age_r <= age_r + 3'h1;
	end
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cmp_d <= 4'h0;
		else
			cmp_d <= {cmp_d[2:0], cmp_below};
	end
	AST_REQ_BELOW: assert property (vdet_reset_req |-> cmp_d[2])
		else $error("reset request without low supply");
	AST_REQ_HOLD: assert property (ok && mode_r == 2'h3 && cmp_d[2] |-> vdet_reset_req)
		else $error("reset request missing");
	AST_MODE_SEL: assert property (ok && mode_r[0] |-> !(mode_r[1] ? undervolt_irq : vdet_reset_req))
		else $error("wrong request kind");
	AST_OFF: assert property (ok && !mode_r[0] |-> !undervolt_irq && !vdet_reset_req)
		else $error("request while disabled");
	AST_IRQ_CROSS: assert property (ok && mode_r == 2'h1 && cmp_d[2] != cmp_d[3] |-> undervolt_irq)
		else $error("crossing without irq");
	AST_IRQ_WHY: assert property (ok && undervolt_irq |-> cmp_d[2] != cmp_d[3])
		else $error("irq without crossing");
	AST_IRQ_PULSE: assert property (undervolt_irq |=> !undervolt_irq)
		else $error("irq longer than one cycle");
	AST_HI_ZERO: assert property ($past(reg_rd) && $past(reg_addr) == 12'hFC7 |-> reg_rdata[7:6] == 2'h0)
		else $error("mode register top bits set");
	cover property (undervolt_irq);
	cover property (vdet_reset_req);
	cover property (reg_wr && reg_addr == undervolt_pkg::FLAGS_THR_ADDR && !reg_wdata[3]);
endmodule
bind supply_undervolt_monitor uv_chk u_chk
(
	.sys_clk(sys_clk), .rst_n(rst_n), .cmp_below(cmp_below), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.undervolt_irq(undervolt_irq), .vdet_reset_req(vdet_reset_req)
);

// ---- supply_cmp_model.sv ----
// Behavioural supply comparator.
// Assumes the bench sets the supply in millivolts.
`timescale 1ns/1ns
module supply_cmp_model
#(
	parameter int THRESH_MV = 4500
)
(
	input  wire logic [12:0] supply_mv,
	output logic             cmp_below
);
	assign cmp_below = int'(supply_mv) < THRESH_MV;
endmodule

// ---- supply_undervolt_monitor_bench.sv ----
// Self-checking bench for the undervoltage monitor.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ns
module supply_undervolt_monitor_bench;
	localparam logic [12:0] HI = 13'h1388, LO = 13'h0FA0;
	localparam logic [11:0] A1 = undervolt_pkg::FLAGS_THR_ADDR, A2 = undervolt_pkg::MODE_EN_ADDR;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [12:0] supply_mv = HI;
	logic        cmp_below;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic        undervolt_irq;
	logic        vdet_reset_req;
	int          fail_count = 0;
	int          tests_run = 0;
	int          pulses;
	int          hits;
	always #10 sys_clk = ~sys_clk;
	supply_cmp_model MODEL (.supply_mv(supply_mv), .cmp_below(cmp_below));
	supply_undervolt_monitor DUT
	(
		.sys_clk(sys_clk), .rst_n(rst_n), .cmp_below(cmp_below), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.undervolt_irq(undervolt_irq), .vdet_reset_req(vdet_reset_req)
	);
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk("rdata", exp, reg_rdata & (a == A1 ? 8'hBF : 8'hFF));
	endtask
	task automatic sup(input logic [12:0] v);
		@(posedge sys_clk);
		supply_mv <= v;
	endtask
	// Count irq pulses and reset request cycles
	task automatic watch(input int n);
		pulses = 0;
		hits = 0;
		repeat (n)
		begin
			@(posedge sys_clk);
			#1;
			pulses += (undervolt_irq === 1'b1);
			hits += (vdet_reset_req === 1'b1);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(A1, 8'h20);
		rd(A2, 8'h00);
		rd(12'h123, 8'h00);
		wr(A2, 8'hFC);
		rd(A2, 8'h3C);
		wr(A2, 8'h00);
		sup(LO);
		watch(8);
		chk("quiet", 8'h00, 8'(pulses + hits));
		rd(A1, 8'h20);
		wr(A2, 8'h01);
		watch(4);
		chk("enable irq", 8'h01, 8'(pulses));
		sup(HI);
		wr(A1, 8'h20);
		wr(A2, 8'h01);
		watch(8);
		sup(LO);
		watch(8);
		chk("fall irq", 8'h01, 8'(pulses));
		chk("no reset", 8'h00, 8'(hits));
		rd(A1, 8'h2C);
		sup(HI);
		watch(8);
		chk("rise irq", 8'h01, 8'(pulses));
		rd(A1, 8'h28);
		wr(A1, 8'h20);
		rd(A1, 8'h20);
		wr(A1, 8'h28);
		rd(A1, 8'h20);
		sup(LO);
		watch(8);
		wr(A2, 8'h00);
		sup(HI);
		watch(8);
		rd(A1, 8'h28);
		wr(A2, 8'h03);
		sup(LO);
		watch(8);
		watch(10);
		chk("reset held", 8'h0A, 8'(hits));
		chk("no irq", 8'h00, 8'(pulses));
		wr(A1, 8'h20);
		rd(A1, 8'h2C);
		sup(HI);
		watch(8);
		watch(6);
		chk("reset off", 8'h00, 8'(hits));
		rd(A2, 8'h03);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(A1, 8'h20);
		rd(A2, 8'h00);
		end_of_test();
	end
	initial
	begin
		#100000;
		fail_count++;
		end_of_test();
	end
endmodule
